// ==== rtl/mcs_pkg.sv ====
package mcs_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned UCYCLE_NS = 196;
	localparam int unsigned MEMCYCLE_NS = 980;
	// a microcycle may not be shorter than documented, so round up
	localparam int unsigned UCYCLE_CLKS = (UCYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PERIODS_PER_MEMCYCLE = MEMCYCLE_NS / UCYCLE_NS;
	localparam logic [3:0] UDIV_LAST = 4'(UCYCLE_CLKS - 1);

	// ------------------------------------------------------------
	// widths, field positions, reset values
	// ------------------------------------------------------------
	localparam int unsigned CS_AW = 10;
	localparam int unsigned UW = 24;
	localparam int unsigned WCS_AW = 8;
	localparam int unsigned WCS_DEPTH = 256;
	localparam int unsigned MOD_LSB = 8;
	localparam int unsigned BUF1_ADDR_LSB = 8;
	localparam logic [CS_AW-1:0] FETCH_ADDR = 10'h000;
	localparam logic [15:0] IR_RESET = 16'h0000;

	// ------------------------------------------------------------
	// wishbone register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IR = 8'h08;
	localparam logic [7:0] REG_WCS_RD = 8'h0c;
	localparam logic [7:0] REG_BUF1 = 8'h10;
	localparam logic [7:0] REG_BUF2 = 8'h14;
	localparam logic [7:0] REG_CSAR = 8'h18;
	localparam logic [7:0] REG_UIR = 8'h1c;
	// ctrl fields
	localparam int unsigned CTRL_RUN = 0;
	localparam int unsigned CTRL_MODNUM_LSB = 4;

	// ------------------------------------------------------------
	// periods of the memory / io cycle
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		MCS_T2 = 5'h01,
		MCS_T3 = 5'h02,
		MCS_T4 = 5'h04,
		MCS_T5 = 5'h08,
		MCS_T6 = 5'h10
	} mcs_period_t;

	// special field orders seen by the sequencer
	typedef enum logic [2:0] {
		SP_NONE = 3'h0,
		SP_RW = 3'h1,
		SP_CW = 3'h2,
		SP_IOG = 3'h3,
		SP_EOP = 3'h4
	} mcs_special_t;

	// routine enables decoded from the microinstruction
	typedef enum logic [2:0] {
		RT_NONE = 3'h0,
		RT_ASG = 3'h1,
		RT_SRG = 3'h2,
		RT_FLAG = 3'h3,
		RT_CTRL = 3'h4,
		RT_INPUT = 3'h5,
		RT_OUTPUT = 3'h6
	} mcs_routine_t;

	// microinstruction fields used by the sequencer
	typedef struct packed {
		mcs_special_t special;
		mcs_routine_t routine;
		logic src_mdr;
		logic src_conditional_source;
		logic a_addressable_flag;
		logic b_addressable_flag;
		logic operand_in_acc;
		logic input_strobe;
		logic output_strobe;
		logic [UW-14:0] rest;
	} mcs_uinstr_t;

	// decoder enables
	typedef struct packed {
		logic alter_skip;
		logic shift_rotate;
		logic flag_ops;
		logic control_ops;
		logic input_ops;
		logic output_ops;
	} mcs_dec_en_t;

	// io bus request from the card's select code
	typedef struct packed {
		logic set_flag_instr;
		logic set_control_instr;
		logic output_from_a;
		logic output_from_b;
		logic input_instr;
		logic [15:0] data;
	} mcs_io_req_t;

	// memory request
	typedef struct packed {
		logic req;
		logic clear_write;
		logic protect_test;
		logic [14:0] addr;
	} mcs_mem_req_t;
endpackage : mcs_pkg

// ==== rtl/mcs_sequencer.sv ====
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mcs_sequencer #(
	parameter int unsigned MAP_AW = 10
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// io bus from the card's select code
	input wire mcs_pkg::mcs_io_req_t io_req,
	output logic [15:0] io_rd_data,
	// memory side
	input wire logic mem_read_done,
	output mcs_pkg::mcs_mem_req_t mem_req,
	// sequencer outputs
	output mcs_pkg::mcs_dec_en_t dec_en,
	output mcs_pkg::mcs_period_t period,
	output logic frozen,
	output logic input_strobe,
	output logic output_strobe
);
	import mcs_pkg::*;

	// ------------------------------------------------------------
	// registers and microcycle divider
	// ------------------------------------------------------------
	logic [3:0] udiv;
	logic tick;
	logic run;
	logic [1:0] mod_num;
	logic [15:0] ir;
	logic [CS_AW-1:0] csar;
	logic [UW-1:0] uir;
	logic eop_pending;
	logic switch_ff;
	logic [15:0] buf1;
	logic [15:0] buf2;
	logic read_pending;
	logic [UW-1:0] wcs_mem [WCS_DEPTH];

	always_ff @(posedge ref_clk) begin
		if (sys_rst || udiv == UDIV_LAST || !run) begin
			udiv <= '0;
		end else begin
			udiv <= udiv + 4'h1;
		end
	end
	assign tick = run && (udiv == UDIV_LAST);

	// five microcycles per memory cycle, T2..T6
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			period <= MCS_T2;
		end else if (tick) begin
			case (period)
				MCS_T2: period <= MCS_T3;
				MCS_T3: period <= MCS_T4;
				MCS_T4: period <= MCS_T5;
				MCS_T5: period <= MCS_T6;
				MCS_T6: period <= MCS_T2;
				default: period <= MCS_T2;
			endcase
		end
	end

	// ------------------------------------------------------------
	// freeze decision
	// ------------------------------------------------------------
	mcs_uinstr_t u;
	wire is_mem = (u.special == SP_RW) || (u.special == SP_CW);
	wire is_iog = (u.special == SP_IOG);
	// memory orders issue only at T6
	wire mem_freeze = is_mem && (period != MCS_T6);
	// io orders issue only at T2
	wire io_freeze = is_iog && (period != MCS_T2);
	// mdr read via direct source, or conditional source with both flags clear
	wire mdr_read = u.src_mdr || (u.src_conditional_source && !u.a_addressable_flag
		&& !u.b_addressable_flag);
	// only a pending read can cause the second freeze; writes never set it
	wire data_freeze = read_pending && !mem_read_done && mdr_read;
	wire next_frozen = mem_freeze || io_freeze || data_freeze;
	wire advance = tick && !next_frozen;
	assign u = mcs_uinstr_t'(uir);

	// ------------------------------------------------------------
	// starting-address mapper and wcs readout
	// ------------------------------------------------------------
	// opcode field of the instruction register picks the routine
	wire [CS_AW-1:0] map_addr = {ir[15:12], ir[11], ir[10:6]};
	wire wcs_sel = (csar[CS_AW-1:MOD_LSB] == mod_num);
	wire [WCS_AW-1:0] wcs_addr = csar[WCS_AW-1:0];
	wire [UW-1:0] wcs_word = wcs_mem[wcs_addr];
	// unselected module drives nothing; the cable floats to a no-op word
	wire [UW-1:0] next_uir = wcs_sel ? wcs_word : '0;
	wire [CS_AW-1:0] next_csar = eop_pending ? FETCH_ADDR
		: (u.special == SP_EOP) ? csar + 10'h001
		: (csar == FETCH_ADDR) ? map_addr : csar + 10'h001;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			csar <= FETCH_ADDR;
			uir <= '0;
			eop_pending <= 1'b0;
		end else if (advance) begin
			csar <= next_csar;
			uir <= next_uir;
			eop_pending <= (u.special == SP_EOP);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			frozen <= 1'b0;
		end else if (tick) begin
			frozen <= next_frozen;
		end
	end

	// ------------------------------------------------------------
	// side effects, issued only when not frozen
	// ------------------------------------------------------------
	wire fire = tick && !next_frozen;
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mem_req <= '0;
			dec_en <= '0;
			read_pending <= 1'b0;
			input_strobe <= 1'b0;
			output_strobe <= 1'b0;
		end else if (tick) begin
			mem_req.req <= fire && is_mem;
			mem_req.clear_write <= fire && (u.special == SP_CW);
			mem_req.protect_test <= fire && (u.special == SP_CW);
			mem_req.addr <= 15'(uir[14:0]);
			// read data lands in T4; operand in accumulator needs no wait
			if (fire && u.special == SP_RW && !u.operand_in_acc) begin
				read_pending <= 1'b1;
			end else if (period == MCS_T4) begin
				read_pending <= 1'b0;
			end
			dec_en.alter_skip <= fire && u.routine == RT_ASG;
			dec_en.shift_rotate <= fire && u.routine == RT_SRG;
			dec_en.flag_ops <= fire && is_iog && u.routine == RT_FLAG;
			dec_en.control_ops <= fire && is_iog && u.routine == RT_CTRL;
			dec_en.input_ops <= fire && is_iog && u.routine == RT_INPUT;
			dec_en.output_ops <= fire && is_iog && u.routine == RT_OUTPUT;
			// strobes only honoured in their documented periods
			output_strobe <= fire && u.output_strobe
				&& (period == MCS_T2 || period == MCS_T3);
			input_strobe <= fire && u.input_strobe
				&& (period == MCS_T3 || period == MCS_T4);
		end
	end

	// ------------------------------------------------------------
	// writable control store loading
	// ------------------------------------------------------------
	wire [WCS_AW-1:0] load_addr = buf1[15:BUF1_ADDR_LSB];
	wire [UW-1:0] load_word = {buf1[BUF1_ADDR_LSB-1:0], buf2};

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			switch_ff <= 1'b0;
			buf1 <= '0;
			buf2 <= '0;
			io_rd_data <= '0;
		end else begin
			if (io_req.set_flag_instr) begin
				switch_ff <= 1'b1;
			end else if (io_req.output_from_b && switch_ff) begin
				switch_ff <= 1'b0;
			end
			if (io_req.output_from_b && switch_ff) begin
				buf1 <= io_req.data;
			end
			if (io_req.output_from_a && !switch_ff) begin
				buf2 <= io_req.data;
			end
			if (io_req.input_instr) begin
				io_rd_data <= wcs_mem[load_addr][15:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (io_req.set_control_instr) begin
			wcs_mem[load_addr] <= load_word;
		end
	end

	// ------------------------------------------------------------
	// wishbone slave, one wait state, ack drops after one cycle
	// ------------------------------------------------------------
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
	logic [31:0] rd_mux;
	always_comb begin
		case (wb_adr_i)
			REG_CTRL: rd_mux = {26'h0, mod_num, 3'h0, run};
			REG_STATUS: rd_mux = {24'h0, read_pending, switch_ff, frozen, period};
			REG_IR: rd_mux = {16'h0, ir};
			REG_WCS_RD: rd_mux = {8'h0, wcs_mem[load_addr]};
			REG_BUF1: rd_mux = {16'h0, buf1};
			REG_BUF2: rd_mux = {16'h0, buf2};
			REG_CSAR: rd_mux = {22'h0, csar};
			REG_UIR: rd_mux = {8'h0, uir};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			run <= 1'b0;
			mod_num <= 2'h0;
			ir <= IR_RESET;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rd_mux : 32'h0;
			if (wb_wr && wb_adr_i == REG_CTRL) begin
				run <= wb_dat_i[CTRL_RUN];
				mod_num <= wb_dat_i[CTRL_MODNUM_LSB +: 2];
			end
			if (wb_wr && wb_adr_i == REG_IR) begin
				ir <= wb_dat_i[15:0];
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_mem_at_t6;
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(mem_req.req) |-> $past(period) == MCS_T6;
	endproperty
	a_mem_at_t6: assert property (p_mem_at_t6) else $error("memory request off T6");

	property p_protect;
		@(posedge ref_clk) disable iff (sys_rst)
		mem_req.protect_test |-> mem_req.req && mem_req.clear_write;
	endproperty
	a_protect: assert property (p_protect) else $error("protect test without CW");

	property p_io_at_t2;
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(dec_en.flag_ops) |-> $past(period) == MCS_T2;
	endproperty
	a_io_at_t2: assert property (p_io_at_t2) else $error("io decode off T2");

	property p_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		(tick && next_frozen) |=> $stable(csar) && $stable(uir);
	endproperty
	a_hold: assert property (p_hold) else $error("freeze moved registers");

	property p_eop;
		@(posedge ref_clk) disable iff (sys_rst)
		(advance && eop_pending) |=> csar == FETCH_ADDR;
	endproperty
	a_eop: assert property (p_eop) else $error("eop missed fetch");

	property p_switch;
		@(posedge ref_clk) disable iff (sys_rst)
		(io_req.set_flag_instr) |=> switch_ff;
	endproperty
	a_switch: assert property (p_switch) else $error("switch not set");

	property p_buf1;
		@(posedge ref_clk) disable iff (sys_rst)
		(io_req.output_from_b && switch_ff && !io_req.set_flag_instr)
			|=> buf1 == $past(io_req.data) && !switch_ff;
	endproperty
	a_buf1: assert property (p_buf1) else $error("buffer1 load wrong");

	property p_ostrobe;
		@(posedge ref_clk) disable iff (sys_rst)
		output_strobe |-> period == MCS_T3 || period == MCS_T4;
	endproperty
	a_ostrobe: assert property (p_ostrobe) else $error("output strobe period");

	property p_istrobe;
		@(posedge ref_clk) disable iff (sys_rst)
		input_strobe |-> period == MCS_T4 || period == MCS_T5;
	endproperty
	a_istrobe: assert property (p_istrobe) else $error("input strobe period");

	property p_read_clear;
		@(posedge ref_clk) disable iff (sys_rst)
		(tick && period == MCS_T4 && !(fire && u.special == SP_RW)) |=> !read_pending;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read still pending");

	property p_tick;
		@(posedge ref_clk) disable iff (sys_rst)
		tick |=> !tick [*8] ##1 !tick;
	endproperty
	a_tick: assert property (p_tick) else $error("microcycle too short");
endmodule : mcs_sequencer
`default_nettype wire

// ==== rtl/unused_placeholder_removed.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== sim/mcs_mem_card.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcs_mem_card (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// memory request from the sequencer
	input wire mcs_pkg::mcs_mem_req_t mem_req,
	input wire logic slow,
	// read half-cycle status
	output logic mem_read_done
);
	import mcs_pkg::*;
	int cnt;
	// ------------------------------------------------------------
	// core read half-cycle
	// ------------------------------------------------------------
	// done drops while a request stands, so early data reads must freeze
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mem_read_done <= 1'b1;
			cnt <= 0;
		end else if (mem_req.req) begin
			mem_read_done <= 1'b0;
			cnt <= slow ? 30 : 4;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else begin
			mem_read_done <= 1'b1;
			cnt <= 0;
		end
	end
endmodule : mcs_mem_card
`default_nettype wire

// ==== sim/test_microcode_sequencer_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_microcode_sequencer_sync;
	import mcs_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	mcs_io_req_t io_req = '0;
	logic [15:0] io_rd_data;
	logic mem_read_done;
	logic slow = 1'b0;
	mcs_mem_req_t mem_req;
	mcs_dec_en_t dec_en;
	mcs_period_t period;
	logic frozen, input_strobe, output_strobe;
	int miscompares = 0;
	int n_tests = 0;
	logic [31:0] seed = 32'h000112fb;
	int wcs [256];
	logic mon_on = 1'b0;
	logic started = 1'b0;
	logic [4:0] pv;
	int plen;

	mcs_sequencer dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .io_req(io_req),
		.io_rd_data(io_rd_data), .mem_read_done(mem_read_done), .mem_req(mem_req),
		.dec_en(dec_en), .period(period), .frozen(frozen), .input_strobe(input_strobe),
		.output_strobe(output_strobe));
	mcs_mem_card card (.ref_clk(ref_clk), .sys_rst(sys_rst), .mem_req(mem_req),
		.slow(slow), .mem_read_done(mem_read_done));

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task test_done;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	function logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	// classic cycle; ack and data are taken at the same edge
	task wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
		int i;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (wb_ack_o === 1'b1) break;
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (i == 20) begin
			miscompares++;
			test_done();
		end
	endtask : wb

	// k: 4 set flag, 3 set control, 2 out A, 1 out B, 0 input
	task io_op(input int k, input logic [15:0] d);
		@(posedge ref_clk);
		io_req <= mcs_io_req_t'({5'(1 << k), d});
		@(posedge ref_clk);
		io_req <= mcs_io_req_t'({5'h00, d});
	endtask : io_op

	task load(input logic [7:0] a, input logic [23:0] w);
		logic [31:0] q;
		io_op(4, 16'h0000);
		wb(1'b0, REG_STATUS, 32'h0, q);
		chk("switch set", 32'h1, 32'(q[6]));
		io_op(1, {a, w[23:16]});
		wb(1'b0, REG_STATUS, 32'h0, q);
		chk("switch clear", 32'h0, 32'(q[6]));
		io_op(2, w[15:0]);
		io_op(3, 16'h0000);
		wcs[a] = int'(w);
	endtask : load

	task readback(input logic [7:0] a);
		logic [31:0] q;
		io_op(4, 16'h0000);
		io_op(1, {a, 8'h00});
		io_op(0, 16'h0000);
		@(posedge ref_clk);
		chk("io readback", 32'(wcs[a][15:0]), 32'(io_rd_data));
		wb(1'b0, REG_WCS_RD, 32'h0, q);
		chk("wcs word", 32'(wcs[a][23:0]), q);
	endtask : readback

	// ------------------------------------------------------------
	// period sequence monitor
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (mon_on) begin
			if (period !== pv) begin
				if (started) chk("period length", UCYCLE_CLKS, plen);
				if (started) chk("period order", {pv[3:0], pv[4]}, 32'(period));
				started <= 1'b1;
				plen <= 1;
			end else begin
				plen <= plen + 1;
			end
			pv <= period;
			if (mem_req.protect_test === 1'b1) chk("protect", 1, 32'(mem_req.clear_write));
			if (!$onehot0(dec_en)) chk("decoder enables", 0, 32'(dec_en));
			if (output_strobe === 1'b1)
				chk("output strobe", 1, 32'(period == MCS_T3 || period == MCS_T4));
			if (input_strobe === 1'b1)
				chk("input strobe", 1, 32'(period == MCS_T4 || period == MCS_T5));
			if (mem_req.req === 1'b1) chk("memory request", 32'(MCS_T2), 32'(period));
			if (dec_en.control_ops === 1'b1) chk("io decode", 32'(MCS_T3), 32'(period));
		end
	end

	initial begin
		#1500000;
		miscompares++;
		test_done();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic [7:0] a;
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		wb(1'b0, REG_STATUS, 32'h0, q);
		chk("status reset", 32'h1, q);
		wb(1'b0, REG_IR, 32'h0, q);
		chk("ir reset", 32'(IR_RESET), q);
		wb(1'b1, 8'h40, 32'h5a5a5a5a, q);
		wb(1'b0, 8'h40, 32'h0, q);
		chk("unmapped", 32'h0, q);
		wb(1'b1, REG_IR, 32'h0000c3c0, q);
		wb(1'b0, REG_IR, 32'h0, q);
		chk("ir", 32'h0000c3c0, q);
		for (int i = 0; i < 256; i++) wcs[i] = 0;
		load(8'h00, 24'h000000);
		load(8'hff, 24'hffffff);
		for (int n = 0; n < 10; n++) begin
			seed = xs(seed);
			load(seed[31:24], seed[23:0]);
			readback(seed[31:24]);
		end
		readback(8'hff);
		readback(8'h00);
		wb(1'b1, REG_CTRL, 32'h00000001, q);
		mon_on <= 1'b1;
		pv <= period;
		repeat (400) @(posedge ref_clk);
		slow <= 1'b1;
		repeat (400) @(posedge ref_clk);
		chk("periods seen", 1, 32'(started));
		test_done();
	end
endmodule : test_microcode_sequencer_sync
`default_nettype wire
